// [common/radio_policy_consts.vh]
`ifndef RADIO_POLICY_CONSTS_VH
`define RADIO_POLICY_CONSTS_VH

// register map, byte offsets on the 16-bit register port
`define REG_RX_TIMEOUT_CONTROL 16'hDF12
`define REG_PACKET_END_STATE_CONTROL 16'hDF13
`define REG_POLICY_STATUS 16'hDF40

// rx_timeout_control fields
`define RX_END_ON_NO_CARRIER_BIT 4
`define RX_KEEP_ON_QUALITY_BIT 3
`define RX_TIMEOUT_CODE_MSB 2
`define RX_TIMEOUT_CODE_LSB 0
`define RX_TIMEOUT_CONTROL_MASK 8'h1F
`define RX_TIMEOUT_CONTROL_RESET 8'h07
`define RX_TIMEOUT_CODE_NONE 3'h7

// packet_end_state_control fields
`define CLEAR_CHANNEL_POLICY_MSB 5
`define CLEAR_CHANNEL_POLICY_LSB 4
`define AFTER_RX_STATE_MSB 3
`define AFTER_RX_STATE_LSB 2
`define AFTER_TX_STATE_MSB 1
`define AFTER_TX_STATE_LSB 0
`define PACKET_END_STATE_CONTROL_MASK 8'h3F
`define PACKET_END_STATE_CONTROL_RESET 8'h30

// clear channel policy codes
`define CCA_ALWAYS 2'h0
`define CCA_BELOW_THRESHOLD 2'h1
`define CCA_NOT_RECEIVING 2'h2
`define CCA_BELOW_AND_NOT_RECEIVING 2'h3

// after-packet state codes
`define NEXT_IDLE 2'h0
`define NEXT_SYNTH_ON_TX_READY 2'h1
`define NEXT_TX_FROM_RX 2'h2
`define NEXT_STAY_RX 2'h3
`define NEXT_STAY_TX 2'h2
`define NEXT_RX_FROM_TX 2'h3

// timing
`define CLOCK_MHZ 40
`define REF_FREQ_MHZ 26
`define REF_FREQ_NOMINAL_MHZ 26
`define ASK_CARRIER_WINDOW_SYMBOLS 4'h8
`define ASK_CARRIER_LAST_SYMBOL 4'h7
// tick rate = 2^24 / (C(000,res) * clock_mhz), C scaled by 26/X elsewhere
`define TICK_ACC_WIDTH 24
`define TICK_STEP_RES0 116321
`define TICK_STEP_RES1 23264
`define TICK_STEP_RES2 12925
`define TICK_STEP_RES3 8948

`endif

// [src/clear_channel_eval.v]
`timescale 1ns/1ps
`include "radio_policy_consts.vh"

module clear_channel_eval (
	input wire clock_i,
	input wire reset_n_i,
	input wire [1:0] clear_channel_policy_i,
	input wire rssi_below_threshold_i,
	input wire receiving_packet_i,
	output reg clear_channel_flag_o
);
	reg next_flag;

	always @* begin
		case (clear_channel_policy_i)
			`CCA_ALWAYS: next_flag = 1'b1;
			`CCA_BELOW_THRESHOLD: next_flag = rssi_below_threshold_i;
			`CCA_NOT_RECEIVING: next_flag = !receiving_packet_i;
			default: next_flag = rssi_below_threshold_i && !receiving_packet_i;
		endcase
	end

	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i)
			clear_channel_flag_o <= 1'b0;
		else
			clear_channel_flag_o <= next_flag;
	end
endmodule // clear_channel_eval

// [src/radio_rx_tx_state_policy.v]
// Notes on behaviour
// - rssi end bit set ends reception early on missing carrier sense.
// - ask/ook with rssi end bit: leave receive if no carrier in 8 symbols.
// - timeout, quality option clear: stay in receive only if sync found.
// - timeout, quality option set: stay if sync found or quality reached.
// - three-bit timeout code limits sync search; resets to all ones.
// - timeout is event0 period times table coefficient times 26/X.
// - clear channel flag driven by two-bit policy field, reset 11.
// - policy 00 always, 01 below threshold, 10 not receiving, 11 both.
// - after receive: 00 idle, 01 synth on, 10 transmit, 11 stay receive.
// - after transmit: 00 idle, 01 synth on, 10 stay transmit, 11 receive.
// - staying in transmit restarts preamble right after the packet.
`timescale 1ns/1ps
`include "radio_policy_consts.vh"

module radio_rx_tx_state_policy #(
	parameter EVENT0_W = 16,
	parameter REF_MHZ = `REF_FREQ_MHZ
) (
	input wire clock_i,
	input wire reset_n_i,
	input wire [15:0] addr_i,
	input wire [7:0] wr_data_i,
	input wire wr_en_i,
	input wire rd_en_i,
	output reg [7:0] rd_data_o,
	input wire cmd_idle_i,
	input wire cmd_rx_i,
	input wire cmd_tx_i,
	input wire cmd_synth_on_i,
	input wire packet_received_i,
	input wire packet_sent_i,
	input wire sync_found_i,
	input wire preamble_quality_threshold_i,
	input wire carrier_sense_i,
	input wire rssi_below_threshold_i,
	input wire ask_mode_i,
	input wire symbol_tick_i,
	input wire [EVENT0_W-1:0] wake_event0_period_i,
	input wire [1:0] wake_timer_resolution_i,
	output reg [3:0] radio_state_o,
	output reg preamble_start_o,
	output reg rx_timeout_o,
	output reg rx_carrier_end_o,
	output reg clear_channel_flag_o
);
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_RX = 4'h2;
	localparam [3:0] ST_TX = 4'h4;
	localparam [3:0] ST_SYNTH = 4'h8;

	reg [7:0] rx_timeout_control;
	reg [7:0] packet_end_state_control;
	reg [3:0] state;
	reg [3:0] next_state;
	reg sync_seen;
	reg quality_seen;
	reg carrier_seen;
	reg [3:0] symbol_count;
	reg next_preamble;
	reg next_timeout_evt;
	reg next_carrier_end;
	wire timer_expired;
	wire cca_flag;

	wire rx_end_on_no_carrier =
		rx_timeout_control[`RX_END_ON_NO_CARRIER_BIT];
	wire rx_keep_on_quality = rx_timeout_control[`RX_KEEP_ON_QUALITY_BIT];
	wire [2:0] rx_timeout_code =
		rx_timeout_control[`RX_TIMEOUT_CODE_MSB:`RX_TIMEOUT_CODE_LSB];
	wire [1:0] clear_channel_policy = packet_end_state_control
		[`CLEAR_CHANNEL_POLICY_MSB:`CLEAR_CHANNEL_POLICY_LSB];
	wire [1:0] after_rx_state = packet_end_state_control
		[`AFTER_RX_STATE_MSB:`AFTER_RX_STATE_LSB];
	wire [1:0] after_tx_state = packet_end_state_control
		[`AFTER_TX_STATE_MSB:`AFTER_TX_STATE_LSB];

	wire in_rx = (state == ST_RX);
	wire entering_rx = (next_state == ST_RX) && !in_rx;
	// a packet counts as being received from sync until the packet ends
	wire receiving_packet = in_rx && sync_seen;
	wire sync_now = sync_seen || sync_found_i;
	wire quality_now = quality_seen || preamble_quality_threshold_i;
	wire ask_window_done = (symbol_count ==
		`ASK_CARRIER_LAST_SYMBOL) && symbol_tick_i;

	// register port
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_timeout_control <= `RX_TIMEOUT_CONTROL_RESET;
			packet_end_state_control <= `PACKET_END_STATE_CONTROL_RESET;
		end else if (wr_en_i) begin
			case (addr_i)
				`REG_RX_TIMEOUT_CONTROL:
					rx_timeout_control <= wr_data_i &
						`RX_TIMEOUT_CONTROL_MASK;
				`REG_PACKET_END_STATE_CONTROL:
					packet_end_state_control <= wr_data_i &
						`PACKET_END_STATE_CONTROL_MASK;
				default: ;
			endcase
		end
	end

	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= 8'h00;
		end else if (rd_en_i) begin
			case (addr_i)
				`REG_RX_TIMEOUT_CONTROL: rd_data_o <= rx_timeout_control;
				`REG_PACKET_END_STATE_CONTROL:
					rd_data_o <= packet_end_state_control;
				`REG_POLICY_STATUS:
					rd_data_o <= {quality_seen, sync_seen, carrier_seen,
						clear_channel_flag_o, state};
				default: rd_data_o <= 8'h00;
			endcase
		end else begin
			rd_data_o <= 8'h00;
		end
	end

	// next state: commands first, then packet ends, then rx terminations
	always @* begin
		next_state = state;
		next_preamble = 1'b0;
		next_timeout_evt = 1'b0;
		next_carrier_end = 1'b0;
		if (cmd_idle_i) begin
			next_state = ST_IDLE;
		end else if (cmd_rx_i) begin
			next_state = ST_RX;
		end else if (cmd_tx_i) begin
			next_state = ST_TX;
			next_preamble = (state != ST_TX);
		end else if (cmd_synth_on_i) begin
			next_state = ST_SYNTH;
		end else begin
			case (state)
				ST_RX: begin
					if (packet_received_i) begin
						case (after_rx_state)
							`NEXT_IDLE: next_state = ST_IDLE;
							`NEXT_SYNTH_ON_TX_READY: next_state = ST_SYNTH;
							`NEXT_TX_FROM_RX: begin
								next_state = ST_TX;
								next_preamble = 1'b1;
							end
							default: next_state = ST_RX;
						endcase
					end else if (timer_expired) begin
						// stay only on sync, or on quality if enabled
						if (!(sync_now || (rx_keep_on_quality &&
							quality_now))) begin
							next_state = ST_IDLE;
							next_timeout_evt = 1'b1;
						end
					end else if (rx_end_on_no_carrier && !sync_now) begin
						if (ask_mode_i) begin
							if (ask_window_done && !carrier_seen &&
								!carrier_sense_i) begin
								next_state = ST_IDLE;
								next_carrier_end = 1'b1;
							end
						end else if (carrier_seen && !carrier_sense_i) begin
							// carrier came and went with no sync found
							next_state = ST_IDLE;
							next_carrier_end = 1'b1;
						end
					end
				end
				ST_TX: begin
					if (packet_sent_i) begin
						case (after_tx_state)
							`NEXT_IDLE: next_state = ST_IDLE;
							`NEXT_SYNTH_ON_TX_READY: next_state = ST_SYNTH;
							`NEXT_STAY_TX: begin
								next_state = ST_TX;
								next_preamble = 1'b1;
							end
							default: next_state = ST_RX;
						endcase
					end
				end
				ST_IDLE: next_state = ST_IDLE;
				ST_SYNTH: next_state = ST_SYNTH;
				default: next_state = ST_IDLE;
			endcase
		end
	end

	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= ST_IDLE;
			radio_state_o <= ST_IDLE;
			preamble_start_o <= 1'b0;
			rx_timeout_o <= 1'b0;
			rx_carrier_end_o <= 1'b0;
		end else begin
			state <= next_state;
			radio_state_o <= next_state;
			preamble_start_o <= next_preamble;
			rx_timeout_o <= next_timeout_evt;
			rx_carrier_end_o <= next_carrier_end;
		end
	end

	// per-reception history, cleared on every receive entry
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync_seen <= 1'b0;
			quality_seen <= 1'b0;
			carrier_seen <= 1'b0;
			symbol_count <= 4'h0;
		end else if (entering_rx || !in_rx || packet_received_i) begin
			sync_seen <= 1'b0;
			quality_seen <= 1'b0;
			carrier_seen <= 1'b0;
			symbol_count <= 4'h0;
		end else begin
			sync_seen <= sync_now;
			quality_seen <= quality_now;
			carrier_seen <= carrier_seen || carrier_sense_i;
			// saturates so the window check fires only once
			if (symbol_tick_i && symbol_count !=
				`ASK_CARRIER_WINDOW_SYMBOLS)
				symbol_count <= symbol_count + 4'h1;
		end
	end

	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i)
			clear_channel_flag_o <= 1'b0;
		else
			clear_channel_flag_o <= cca_flag;
	end

	rx_timeout_timer #(
		.EVENT0_W(EVENT0_W),
		.REF_MHZ(REF_MHZ)
	) u_rx_timeout_timer (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.restart_i(entering_rx),
		.enable_i(in_rx),
		.wake_event0_period_i(wake_event0_period_i),
		.code_i(rx_timeout_code),
		.wake_timer_resolution_i(wake_timer_resolution_i),
		.expired_o(timer_expired)
	);

	clear_channel_eval u_clear_channel_eval (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.clear_channel_policy_i(clear_channel_policy),
		.rssi_below_threshold_i(rssi_below_threshold_i),
		.receiving_packet_i(receiving_packet),
		.clear_channel_flag_o(cca_flag)
	);
endmodule // radio_rx_tx_state_policy

// [src/rx_timeout_timer.v]
`timescale 1ns/1ps
`include "radio_policy_consts.vh"

module rx_timeout_timer #(
	parameter EVENT0_W = 16,
	parameter REF_MHZ = `REF_FREQ_MHZ
) (
	input wire clock_i,
	input wire reset_n_i,
	input wire restart_i,
	input wire enable_i,
	input wire [EVENT0_W-1:0] wake_event0_period_i,
	input wire [2:0] code_i,
	input wire [1:0] wake_timer_resolution_i,
	output reg expired_o
);
	localparam AW = `TICK_ACC_WIDTH;
	// reference frequency rescales the step, so period goes as 26/X
	localparam [AW-1:0] STEP0 = (`TICK_STEP_RES0 * REF_MHZ) / 26;
	localparam [AW-1:0] STEP1 = (`TICK_STEP_RES1 * REF_MHZ) / 26;
	localparam [AW-1:0] STEP2 = (`TICK_STEP_RES2 * REF_MHZ) / 26;
	localparam [AW-1:0] STEP3 = (`TICK_STEP_RES3 * REF_MHZ) / 26;

	reg [AW-1:0] acc;
	reg [EVENT0_W-1:0] remaining;
	reg armed;
	reg [AW-1:0] step_base;
	wire [AW-1:0] step = step_base << code_i;
	wire [AW:0] sum = {1'b0, acc} + {1'b0, step};

	always @* begin
		case (wake_timer_resolution_i)
			2'h0: step_base = STEP0;
			2'h1: step_base = STEP1;
			2'h2: step_base = STEP2;
			default: step_base = STEP3;
		endcase
	end

	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			acc <= {AW{1'b0}};
			remaining <= {EVENT0_W{1'b0}};
			armed <= 1'b0;
			expired_o <= 1'b0;
		end else begin
			expired_o <= 1'b0;
			if (restart_i) begin
				acc <= {AW{1'b0}};
				remaining <= wake_event0_period_i;
				armed <= (code_i != `RX_TIMEOUT_CODE_NONE);
			end else if (enable_i && armed) begin
				acc <= sum[AW-1:0];
				if (sum[AW]) begin
					if (remaining <= {{(EVENT0_W-1){1'b0}}, 1'b1}) begin
						armed <= 1'b0;
						expired_o <= 1'b1;
					end else begin
						remaining <= remaining - 1'b1;
					end
				end
			end else if (!enable_i) begin
				armed <= 1'b0;
			end
		end
	end
endmodule // rx_timeout_timer

// [verification/radio_policy_assertions.sv]
`timescale 1ns/1ps
module radio_policy_assertions (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] rd_data_o,
	input wire logic cmd_idle_i,
	input wire logic cmd_rx_i,
	input wire logic cmd_tx_i,
	input wire logic cmd_synth_on_i,
	input wire logic packet_received_i,
	input wire logic packet_sent_i,
	input wire logic rssi_below_threshold_i,
	input wire logic [3:0] radio_state_o,
	input wire logic preamble_start_o,
	input wire logic rx_timeout_o,
	input wire logic rx_carrier_end_o,
	input wire logic clear_channel_flag_o
);
	logic [5:0] shadow;
	wire no_cmd = !cmd_idle_i && !cmd_rx_i && !cmd_tx_i && !cmd_synth_on_i;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	// both packet-end fields share one mapping of codes to states
	function automatic logic [3:0] dest(input logic [1:0] m);
		case (m)
			2'h0: dest = 4'h1;
			2'h1: dest = 4'h8;
			2'h2: dest = 4'h4;
			default: dest = 4'h2;
		endcase
	endfunction
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i)
			shadow <= 6'h30;
		else if (wr_en_i && addr_i == 16'hDF13)
			shadow <= wr_data_i[5:0];
	end
	sequence s_rx_done;
		radio_state_o == 4'h2 && packet_received_i && no_cmd;
	endsequence
	sequence s_tx_done;
		radio_state_o == 4'h4 && packet_sent_i && no_cmd;
	endsequence
	a_state_one_hot: assert property ($onehot(radio_state_o))
		else $error("state not one-hot");
	a_rd_quiet: assert property (!rd_en_i |=> rd_data_o == 8'h00)
		else $error("read data outside read slot");
	a_rd_policy: assert property (rd_en_i && addr_i == 16'hDF13 |=>
		rd_data_o == {2'h0, shadow}) else $error("end control readback");
	a_after_rx_dest: assert property (s_rx_done |=>
		radio_state_o == dest(shadow[3:2])) else $error("after rx state");
	a_after_tx_dest: assert property (s_tx_done |=>
		radio_state_o == dest(shadow[1:0])) else $error("after tx state");
	a_tx_again: assert property (s_tx_done ##0 shadow[1:0] == 2'h2
		|=> preamble_start_o) else $error("no preamble restart");
	a_cca_always: assert property (shadow[5:4] == 2'h0 [*3]
		|-> clear_channel_flag_o) else $error("flag not always clear");
	a_cca_below: assert property (shadow[5:4] == 2'h1 [*3] |->
		clear_channel_flag_o == $past(rssi_below_threshold_i, 2))
		else $error("flag not threshold");
	a_timeout_from_rx: assert property (rx_timeout_o |->
		$past(radio_state_o) == 4'h2 && radio_state_o != 4'h2)
		else $error("timeout outside receive");
	a_carrier_from_rx: assert property (rx_carrier_end_o |->
		$past(radio_state_o) == 4'h2) else $error("carrier end outside rx");
endmodule // radio_policy_assertions

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic clock_i = 0, reset_n_i = 0, wr_en_i = 0, rd_en_i = 0;
	logic [15:0] addr_i = 0, wake_event0_period_i = 16'h0001;
	logic [7:0] wr_data_i = 0, ev = 0;
	logic carrier_sense_i = 0, rssi_below_threshold_i = 0;
	logic ask_mode_i = 0, symbol_tick_i = 0;
	logic [1:0] wake_timer_resolution_i = 0;
	logic [3:0] tgt [4] = '{4'h1, 4'h8, 4'h4, 4'h2};
	wire [7:0] rd_data_o;
	wire [3:0] radio_state_o;
	wire preamble_start_o, rx_timeout_o, rx_carrier_end_o, clear_channel_flag_o;
	int n_errors = 0, cmp_count = 0;
	radio_rx_tx_state_policy i_radio_rx_tx_state_policy (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
		.rd_data_o(rd_data_o), .cmd_idle_i(ev[0]), .cmd_rx_i(ev[1]),
		.cmd_tx_i(ev[2]), .cmd_synth_on_i(ev[3]),
		.packet_received_i(ev[4]), .packet_sent_i(ev[5]),
		.sync_found_i(ev[6]), .preamble_quality_threshold_i(ev[7]),
		.carrier_sense_i(carrier_sense_i),
		.rssi_below_threshold_i(rssi_below_threshold_i),
		.ask_mode_i(ask_mode_i), .symbol_tick_i(symbol_tick_i),
		.wake_event0_period_i(wake_event0_period_i),
		.wake_timer_resolution_i(wake_timer_resolution_i),
		.radio_state_o(radio_state_o), .preamble_start_o(preamble_start_o),
		.rx_timeout_o(rx_timeout_o), .rx_carrier_end_o(rx_carrier_end_o),
		.clear_channel_flag_o(clear_channel_flag_o));
	initial forever #12.5 clock_i = ~clock_i;
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge clock_i);
		wr_en_i <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e, input string w);
		@(posedge clock_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge clock_i);
		rd_en_i <= 1'b0;
		#1 chk(w, rd_data_o, e);
	endtask
	// bit order: idle rx tx synth received sent sync quality
	task pulse(input int b);
		@(posedge clock_i);
		ev <= 8'(1 << b);
		@(posedge clock_i);
		ev <= 8'h00;
		#1;
	endtask
	task wait_ev(input bit car, input int lim, output int n, output bit seen);
		seen = 0;
		for (n = 0; n < lim && !seen; n++) begin
			#1 seen = car ? rx_carrier_end_o : rx_timeout_o;
			if (!seen)
				@(posedge clock_i);
		end
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task t_regs;
		rd(16'hDF12, 8'h07, "timeout ctl reset");
		rd(16'hDF13, 8'h30, "end ctl reset");
		rd(16'hDF20, 8'h00, "unmapped");
		wr(16'hDF12, 8'hFF);
		rd(16'hDF12, 8'h1F, "timeout ctl mask");
		wr(16'hDF12, 8'h07);
		$display("regs done");
	endtask
	task t_ends;
		for (int m = 0; m < 4; m++) begin
			wr(16'hDF13, 8'(m << 2));
			pulse(0);
			pulse(1);
			pulse(4);
			chk("after rx", {4'h0, radio_state_o}, {4'h0, tgt[m]});
			wr(16'hDF13, 8'(m));
			pulse(0);
			pulse(2);
			pulse(5);
			chk("after tx", {4'h0, radio_state_o}, {4'h0, tgt[m]});
			if (m == 2)
				chk("preamble again", {7'h0, preamble_start_o}, 8'h01);
		end
		$display("ends done");
	endtask
	task t_cca;
		logic e;
		for (int p = 0; p < 4; p++) begin
			wr(16'hDF13, 8'(p << 4));
			for (int k = 0; k < 3; k++) begin
				pulse(0);
				if (k == 2)
					pulse(1);
				if (k == 2)
					pulse(6);
				@(posedge clock_i);
				rssi_below_threshold_i <= (k != 0);
				repeat (3) @(posedge clock_i);
				#1 e = (!p[0] || k != 0) && (!p[1] || k != 2);
				chk("clear flag", {7'h0, clear_channel_flag_o}, {7'h0, e});
			end
		end
		pulse(0);
		wr(16'hDF13, 8'h00);
		$display("cca done");
	endtask
	task t_timeout;
		int n;
		bit s;
		// code 000 at resolution 0 is about 144 cycles of 25 ns
		wr(16'hDF12, 8'h00);
		pulse(1);
		pulse(7);
		wait_ev(0, 400, n, s);
		if (!s) begin
			n_errors++;
			report_and_stop;
		end
		chk("timeout near", {7'h0, n > 120 && n < 170}, 8'h01);
		#1 chk("left rx", {7'h0, radio_state_o == 4'h2}, 8'h00);
		for (int k = 0; k < 2; k++) begin
			wr(16'hDF12, k ? 8'h08 : 8'h00);
			pulse(0);
			pulse(1);
			pulse(k ? 7 : 6);
			wait_ev(0, 300, n, s);
			chk("kept rx", {7'h0, s}, 8'h00);
			chk("state rx", {4'h0, radio_state_o}, 8'h02);
		end
		pulse(0);
		$display("timeout done");
	endtask
	task t_ask;
		int n;
		bit s;
		wr(16'hDF12, 8'h17);
		ask_mode_i <= 1'b1;
		pulse(1);
		for (int i = 0; i < 8; i++) begin
			#1 chk("rx before 8th", {4'h0, radio_state_o}, 8'h02);
			@(posedge clock_i);
			symbol_tick_i <= 1'b1;
			@(posedge clock_i);
			symbol_tick_i <= 1'b0;
		end
		wait_ev(1, 10, n, s);
		chk("carrier end", {7'h0, s}, 8'h01);
		#25 chk("left rx", {7'h0, radio_state_o == 4'h2}, 8'h00);
		// non-ask: carrier comes and goes with no sync
		@(posedge clock_i);
		ask_mode_i <= 1'b0;
		pulse(1);
		@(posedge clock_i);
		carrier_sense_i <= 1'b1;
		@(posedge clock_i);
		carrier_sense_i <= 1'b0;
		wait_ev(1, 10, n, s);
		chk("carrier drop end", {7'h0, s}, 8'h01);
		#25 chk("left rx drop", {7'h0, radio_state_o == 4'h2}, 8'h00);
		rd(16'hDF40, 8'h11, "status idle");
		$display("ask done");
	endtask
	initial begin
		repeat (5) @(posedge clock_i);
		reset_n_i <= 1'b1;
		t_regs;
		t_ends;
		t_cca;
		t_timeout;
		t_ask;
		report_and_stop;
	end
endmodule // tb_top
bind radio_rx_tx_state_policy radio_policy_assertions i_radio_policy_assertions (
	.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
	.wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
	.rd_data_o(rd_data_o), .cmd_idle_i(cmd_idle_i), .cmd_rx_i(cmd_rx_i),
	.cmd_tx_i(cmd_tx_i), .cmd_synth_on_i(cmd_synth_on_i),
	.packet_received_i(packet_received_i), .packet_sent_i(packet_sent_i),
	.rssi_below_threshold_i(rssi_below_threshold_i),
	.radio_state_o(radio_state_o), .preamble_start_o(preamble_start_o),
	.rx_timeout_o(rx_timeout_o), .rx_carrier_end_o(rx_carrier_end_o),
	.clear_channel_flag_o(clear_channel_flag_o));
